// ===== src/slu_consts.vh
`ifndef SLU_CONSTS_VH
`define SLU_CONSTS_VH

// Opcode fields of the instruction word (24 bits).
`define SLU_OP_MEM 8'hD4
`define SLU_OP_REG 8'hD0
`define SLU_OP_MULTI 8'hDD
`define SLU_MULTI_LIT 4'h4
`define SLU_MULTI_REG 4'h0
`define SLU_MULTI_MASK 4'h7
`define SLU_DEFAULT_REG 4'h0
`define SLU_MAX_COUNT 5'h0F
`define SLU_MAX_ADDR 13'h1FFF

// Addressing modes of the one-bit register form.
`define SLU_AM_DIRECT 3'h0
`define SLU_AM_IND 3'h1
`define SLU_AM_POSTINC 3'h2
`define SLU_AM_POSTDEC 3'h3
`define SLU_AM_PREINC 3'h4
`define SLU_AM_PREDEC 3'h5

// Flag positions in the processor status word.
`define SLU_SR_C 0
`define SLU_SR_Z 1
`define SLU_SR_N 3
`define SLU_SR_RESET 16'h0000

`endif

// ===== src/slu_shift_left_unit.v
// Function
// RULE1: Memory form reads address, shifts one, writes.
// RULE2: Byte shift: bit7 to carry, zero in.
// RULE3: Word shift: bit15 to carry, zero in.
// RULE4: Destination bit selects W0 or memory.
// RULE5: Size bit zero word, one byte.
// RULE6: Decode memory form from prefix D4.
// RULE7: Register form, direct or indirect modes.
// RULE8: Decode register form from prefix D0.
// RULE9: One-bit forms update N, Z, C only.
// RULE10: Literal form shifts by 4-bit count.
// RULE11: Literal form uses direct registers only.
// RULE12: Decode literal form, prefix DD, d100.
// RULE13: Register count uses low five bits.
// RULE14: Count above fifteen yields zero.
// RULE15: Register count form decoded with d000.
// RULE16: Multi-bit forms are word only.
// RULE17: One word, one cycle each.
// RULE18: Multi-bit forms set N, Z, keep C.
`timescale 1ns/1ps
`include "slu_consts.vh"

module slu_shift_left_unit (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Instruction from the decoder
    input wire instr_valid,
    input wire [23:0] instr_word,
    // Working register file read ports
    output wire [3:0] rd_a_addr,
    input wire [15:0] rd_a_data,
    output wire [3:0] rd_b_addr,
    input wire [15:0] rd_b_data,
    // Data memory read port and indirect operand data
    output wire [12:0] mem_rd_addr,
    input wire [15:0] mem_rd_data,
    output wire [15:0] ind_rd_addr,
    input wire [15:0] ind_rd_data,
    // Working register write port
    output reg default_work_reg_we_q,
    output reg [3:0] default_work_reg_waddr_q,
    output reg [15:0] default_work_reg_wdata_q,
    // Pointer update write port for indirect modes
    output reg ptr_we_q,
    output reg [3:0] ptr_waddr_q,
    output reg [15:0] ptr_wdata_q,
    // Data memory write port
    output reg mem_we_q,
    output reg mem_byte_q,
    output reg [15:0] mem_waddr_q,
    output reg [15:0] mem_wdata_q,
    // Processor status word
    output reg [15:0] processor_status_word_q,
    // Decode status
    output wire shift_left_op,
    output reg illegal_q
);

    wire [7:0] prefix = instr_word[23:16];
    wire [3:0] multi_pat = instr_word[7:4] & `SLU_MULTI_MASK;
    reg is_mem;
    reg is_reg;
    reg is_lit;
    reg is_cnt;
    // The forms share one opcode space, so a single case keeps them exclusive.
    always @*
    begin
        is_mem = 1'b0;
        is_reg = 1'b0;
        is_lit = 1'b0;
        is_cnt = 1'b0;
        if (!instr_word[15])
        begin
            case (prefix)
                `SLU_OP_MEM:
                begin
                    is_mem = 1'b1; // RULE6
                end
                `SLU_OP_REG:
                begin
                    is_reg = 1'b1; // RULE8
                end
                `SLU_OP_MULTI:
                begin
                    is_lit = multi_pat == `SLU_MULTI_LIT; // RULE12
                    is_cnt = multi_pat == `SLU_MULTI_REG; // RULE15
                end
                default:
                begin
                    is_mem = 1'b0;
                end
            endcase
        end
    end
    wire byte_op = instr_word[14]; // RULE5
    wire dest_mem = instr_word[13]; // RULE4
    wire [12:0] f_addr = instr_word[12:0];
    wire [2:0] dst_mode = instr_word[13:11];
    wire [3:0] dst_reg = instr_word[10:7];
    wire [2:0] src_mode = instr_word[6:4];
    wire [3:0] src_reg = instr_word[3:0];
    wire [3:0] base_work_reg = instr_word[14:11];
    wire [3:0] dest_work_reg = {instr_word[10:8], instr_word[7]};
    wire [3:0] literal_count_4bit = instr_word[3:0];
    wire [3:0] count_reg = instr_word[3:0];

    // Port A is the source or base register, port B the destination or count register.
    reg [3:0] port_a_sel;
    reg [3:0] port_b_sel;
    always @*
    begin
        port_a_sel = src_reg;
        port_b_sel = dst_reg;
        if (is_lit || is_cnt) // RULE11
        begin
            port_a_sel = base_work_reg;
        end
        if (is_cnt) // RULE15
        begin
            port_b_sel = count_reg;
        end
    end
    assign rd_a_addr = port_a_sel;
    assign rd_b_addr = port_b_sel;
    assign mem_rd_addr = f_addr; // RULE1
    assign shift_left_op = instr_valid && (is_mem || is_reg || is_lit || is_cnt);

    // Effective addresses; pre-modify modes use the stepped pointer.
    wire [15:0] step = byte_op ? 16'h0001 : 16'h0002;
    reg [15:0] src_ea;
    reg [15:0] dst_ea;
    reg mode_ok;
    always @*
    begin
        src_ea = rd_a_data;
        dst_ea = rd_b_data;
        mode_ok = (src_mode <= `SLU_AM_PREDEC) && (dst_mode <= `SLU_AM_PREDEC); // RULE7
        if (src_mode == `SLU_AM_PREINC)
            src_ea = rd_a_data + step;
        else if (src_mode == `SLU_AM_PREDEC)
            src_ea = rd_a_data - step;
        if (dst_mode == `SLU_AM_PREINC)
            dst_ea = rd_b_data + step;
        else if (dst_mode == `SLU_AM_PREDEC)
            dst_ea = rd_b_data - step;
    end
    assign ind_rd_addr = src_ea;

    function [15:0] ptr_next;
        input [2:0] mode;
        input [15:0] ptr;
        input [15:0] stp;
        begin
            case (mode)
                `SLU_AM_POSTINC, `SLU_AM_PREINC: ptr_next = ptr + stp;
                `SLU_AM_POSTDEC, `SLU_AM_PREDEC: ptr_next = ptr - stp;
                default: ptr_next = ptr;
            endcase
        end
    endfunction

    // One-bit shift operand and result.
    wire [15:0] one_src = is_mem ? mem_rd_data :
                          (src_mode == `SLU_AM_DIRECT ? rd_a_data : ind_rd_data);
    reg [15:0] one_res;
    reg one_c;
    reg one_n;
    reg one_z;
    // A byte shift leaves the upper byte of the operand in place.
    always @*
    begin
        if (byte_op) // RULE5
        begin
            one_res = {one_src[15:8], one_src[6:0], 1'b0}; // RULE2
            one_c = one_src[7]; // RULE2
            one_n = one_res[7];
            one_z = one_res[7:0] == 8'h00;
        end
        else
        begin
            one_res = {one_src[14:0], 1'b0}; // RULE3
            one_c = one_src[15]; // RULE3
            one_n = one_res[15];
            one_z = one_res == 16'h0000;
        end
    end

    // A direct byte destination keeps its own upper byte, unlike the memory form.
    reg [15:0] reg_wdata;
    always @*
    begin
        if (byte_op)
            reg_wdata = {rd_b_data[15:8], one_res[7:0]};
        else
            reg_wdata = one_res;
    end

    // Multi-bit shift; counts past fifteen clear the word.
    reg [4:0] cnt5;
    reg [15:0] multi_res;
    always @*
    begin
        if (is_lit)
            cnt5 = {1'b0, literal_count_4bit}; // RULE10
        else
            cnt5 = rd_b_data[4:0]; // RULE13
        // Only four bits reach the shifter; the fifth count bit clears the word instead.
        if (cnt5 > `SLU_MAX_COUNT)
            multi_res = 16'h0000; // RULE14
        else
            multi_res = rd_a_data << cnt5[3:0]; // RULE16
    end

    // A reserved register mode or an unknown multi-bit pattern is flagged, not dropped,
    // so that the decoder can trap it.
    wire bad_form = (is_reg && !mode_ok) || (prefix == `SLU_OP_MULTI && !is_lit && !is_cnt);

    // Every form retires in the cycle it is presented.
    always @(posedge clock or posedge rst) // RULE17
    begin
        if (rst)
        begin
            default_work_reg_we_q <= 1'b0;
            default_work_reg_waddr_q <= 4'h0;
            default_work_reg_wdata_q <= 16'h0000;
            ptr_we_q <= 1'b0;
            ptr_waddr_q <= 4'h0;
            ptr_wdata_q <= 16'h0000;
            mem_we_q <= 1'b0;
            mem_byte_q <= 1'b0;
            mem_waddr_q <= 16'h0000;
            mem_wdata_q <= 16'h0000;
            processor_status_word_q <= `SLU_SR_RESET;
            illegal_q <= 1'b0;
        end
        else
        begin
            default_work_reg_we_q <= 1'b0;
            ptr_we_q <= 1'b0;
            mem_we_q <= 1'b0;
            illegal_q <= 1'b0;
            if (instr_valid && is_mem)
            begin
                processor_status_word_q[`SLU_SR_C] <= one_c; // RULE9
                processor_status_word_q[`SLU_SR_Z] <= one_z;
                processor_status_word_q[`SLU_SR_N] <= one_n;
                mem_byte_q <= byte_op;
                if (dest_mem) // RULE4
                begin
                    mem_we_q <= 1'b1; // RULE1
                    mem_waddr_q <= {3'h0, f_addr};
                    mem_wdata_q <= one_res;
                end
                else
                begin
                    // A byte result into W0 takes its upper byte from the memory operand.
                    default_work_reg_we_q <= 1'b1;
                    default_work_reg_waddr_q <= `SLU_DEFAULT_REG;
                    default_work_reg_wdata_q <= one_res;
                end
            end
            else if (instr_valid && is_reg && mode_ok) // RULE7
            begin
                processor_status_word_q[`SLU_SR_C] <= one_c; // RULE9
                processor_status_word_q[`SLU_SR_Z] <= one_z;
                processor_status_word_q[`SLU_SR_N] <= one_n;
                mem_byte_q <= byte_op;
                if (dst_mode == `SLU_AM_DIRECT)
                begin
                    default_work_reg_we_q <= 1'b1;
                    default_work_reg_waddr_q <= dst_reg;
                    default_work_reg_wdata_q <= reg_wdata;
                end
                else
                begin
                    mem_we_q <= 1'b1;
                    mem_waddr_q <= dst_ea;
                    mem_wdata_q <= one_res;
                end
                if (src_mode != `SLU_AM_DIRECT && src_mode != `SLU_AM_IND)
                begin
                    ptr_we_q <= 1'b1;
                    ptr_waddr_q <= src_reg;
                    ptr_wdata_q <= ptr_next(src_mode, rd_a_data, step);
                end
                // The destination pointer update wins whenever both modes step a pointer.
                if (dst_mode != `SLU_AM_DIRECT && dst_mode != `SLU_AM_IND)
                begin
                    ptr_we_q <= 1'b1;
                    ptr_waddr_q <= dst_reg;
                    ptr_wdata_q <= ptr_next(dst_mode, rd_b_data, step);
                end
            end
            else if (instr_valid && (is_lit || is_cnt)) // RULE11 RULE15
            begin
                default_work_reg_we_q <= 1'b1;
                default_work_reg_waddr_q <= dest_work_reg;
                default_work_reg_wdata_q <= multi_res;
                processor_status_word_q[`SLU_SR_N] <= multi_res[15]; // RULE18
                processor_status_word_q[`SLU_SR_Z] <= multi_res == 16'h0000; // RULE18
            end
            else if (instr_valid && bad_form)
            begin
                illegal_q <= 1'b1;
            end
        end
    end

endmodule // slu_shift_left_unit

// ===== testbench/slu_monitor.sv
`timescale 1ns/1ps
`include "slu_consts.vh"
module slu_monitor (
    input wire logic clock, rst, instr_valid, default_work_reg_we_q, ptr_we_q, mem_we_q, illegal_q,
    input wire logic [23:0] instr_word,
    input wire logic [15:0] rd_a_data, rd_b_data, mem_rd_data, default_work_reg_wdata_q,
    input wire logic [15:0] mem_waddr_q, mem_wdata_q, processor_status_word_q,
    input wire logic [3:0] default_work_reg_waddr_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic [7:0] op = instr_word[23:16];
    wire logic [15:0] sr = processor_status_word_q;
    wire logic vm = instr_valid && op == `SLU_OP_MEM;
    wire logic vd = instr_valid && op == `SLU_OP_MULTI;
    wire logic vl = vd && instr_word[6:4] == 3'h4;
    wire logic vr = vd && instr_word[6:4] == 3'h0;
    AST_MEM_WR: assert property (vm && instr_word[13] |=> mem_we_q && mem_wdata_q ==
        ($past(instr_word[14]) ? {$past(mem_rd_data[15:8]), $past(mem_rd_data[6:0]), 1'b0}
        : {$past(mem_rd_data[14:0]), 1'b0}) && mem_waddr_q == {3'h0, $past(instr_word[12:0])})
        else $error("memory write wrong");
    AST_MEM_W0: assert property (vm && !instr_word[13] |=> default_work_reg_we_q && !mem_we_q
        && default_work_reg_waddr_q == `SLU_DEFAULT_REG) else $error("default register write wrong");
    AST_BYTE_C: assert property (vm && instr_word[14] |=>
        sr[`SLU_SR_C] == $past(mem_rd_data[7])) else $error("byte carry wrong");
    AST_WORD_C: assert property (vm && !instr_word[14] |=>
        sr[`SLU_SR_C] == $past(mem_rd_data[15])) else $error("word carry wrong");
    AST_SR_OTHER: assert property (instr_valid |=> (sr & 16'hFFF4) == ($past(sr) & 16'hFFF4))
        else $error("status bit outside N Z C changed");
    AST_LIT: assert property (vl |=> default_work_reg_we_q &&
        default_work_reg_wdata_q == $past(rd_a_data) << $past(instr_word[3:0])) else $error("literal shift wrong");
    AST_CNT: assert property (vr |=> default_work_reg_wdata_q ==
        ($past(rd_b_data[4]) ? 16'h0 : $past(rd_a_data) << $past(rd_b_data[3:0])))
        else $error("count shift wrong");
    AST_KEEP_C: assert property (vl || vr |=> sr[0] == $past(sr[0]) &&
        sr[1] == (default_work_reg_wdata_q == 16'h0) && sr[3] == default_work_reg_wdata_q[15]) else $error("multi flags wrong");
    AST_ILLEGAL: assert property (vd && instr_word[5:4] != 2'h0 |=> illegal_q && !default_work_reg_we_q)
        else $error("bad pattern accepted");
    AST_IDLE: assert property (!instr_valid |=> !default_work_reg_we_q && !mem_we_q && !ptr_we_q)
        else $error("write without instruction");
    cover property (vl);
    cover property (vr && rd_b_data[4]);
    cover property (vm && instr_word[14]);
endmodule // slu_monitor
bind slu_shift_left_unit slu_monitor mon (.*);

// ===== testbench/slu_partner.sv
`timescale 1ns/1ps
module slu_partner (
    // Read addresses from the unit
    input wire logic [3:0] rd_a_addr,
    input wire logic [3:0] rd_b_addr,
    input wire logic [12:0] mem_rd_addr,
    input wire logic [15:0] ind_rd_addr,
    // Read data back to the unit
    output logic [15:0] rd_a_data,
    output logic [15:0] rd_b_data,
    output logic [15:0] mem_rd_data,
    output logic [15:0] ind_rd_data
);
    logic [15:0] regs [16];
    logic [15:0] mem_word;
    logic [15:0] ind_word;
    // Memory gives one word for every address, so the bench checks the write address itself.
    initial
    begin
        for (int i = 0; i < 16; i++)
            regs[i] = 16'hC3A5 >> i;
        mem_word = 16'h0;
        ind_word = 16'h0;
    end
    assign rd_a_data = regs[rd_a_addr];
    assign rd_b_data = regs[rd_b_addr];
    assign mem_rd_data = mem_word;
    assign ind_rd_data = ind_word;
endmodule // slu_partner

// ===== testbench/test_shift_left_unit.sv
`timescale 1ns/1ps
module test_shift_left_unit;
    logic clock = 0, rst = 1, instr_valid = 0;
    logic [23:0] instr_word = 0;
    wire [3:0] rd_a_addr, rd_b_addr, default_work_reg_waddr_q, ptr_waddr_q;
    wire [12:0] mem_rd_addr;
    wire [15:0] rd_a_data, rd_b_data, ind_rd_addr, mem_rd_data, ind_rd_data, ptr_wdata_q;
    wire [15:0] default_work_reg_wdata_q, mem_waddr_q, mem_wdata_q, processor_status_word_q;
    wire default_work_reg_we_q, ptr_we_q, mem_we_q, mem_byte_q, shift_left_op, illegal_q;
    logic [15:0] esr = 0, e;
    logic [31:0] lf = 70604;
    int fails = 0, check_count = 0, cyc = 0, k;
    slu_shift_left_unit dut (.*);
    slu_partner p (.*);
    initial forever #12.5 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            summarize();
        end
    end
    function automatic [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Flags the status word should hold; multi-bit forms keep carry.
    function automatic [15:0] fl(input [15:0] o, r, input b, c, keep);
        fl = o;
        fl[3] = b ? r[7] : r[15];
        fl[1] = b ? r[7:0] == 0 : r == 0;
        if (!keep)
            fl[0] = c;
    endfunction
    // Forms that should decode; reserved register modes still count as decoded.
    function automatic bit dec(input [23:0] w);
        dec = !w[15] && (w[23:16] == 8'hD4 || w[23:16] == 8'hD0
              || (w[23:16] == 8'hDD && (w[6:4] == 3'h0 || w[6:4] == 3'h4)));
    endfunction
    task chk(input [15:0] g, x);
        check_count++;
        if (g !== x)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task run(input [23:0] w);
        @(posedge clock);
        #1 instr_valid = 1;
        instr_word = w;
        #1 chk({15'h0, shift_left_op}, {15'h0, dec(w)});
        @(posedge clock);
        #1 instr_valid = 0;
    endtask
    task summarize;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        #1 rst = 0;
        p.mem_word = 16'h4065;
        run(24'hD41FFF);
        chk(default_work_reg_wdata_q, 16'h80CA);
        chk({12'h0, default_work_reg_waddr_q}, 16'h0);
        chk({3'h0, mem_rd_addr}, 16'h1FFF);
        esr = fl(esr, 16'h80CA, 0, 0, 0);
        chk(processor_status_word_q, esr);
        p.mem_word = 16'h12A9;
        run(24'hD46909);
        chk(mem_wdata_q & 16'h00FF, 16'h0052);
        chk({mem_byte_q, mem_we_q, mem_waddr_q[13:0]}, 16'hC909);
        esr = fl(esr, 16'h0052, 1, 1, 0);
        chk(processor_status_word_q, esr);
        $display("memory form done");
        p.regs[3] = 16'h78A9;
        p.regs[4] = 16'h1005;
        run(24'hD04203);
        chk(default_work_reg_wdata_q, 16'h1052);
        p.regs[2] = 16'h0900;
        p.regs[12] = 16'h1002;
        p.ind_word = 16'h800F;
        run(24'hD00E22);
        chk(mem_wdata_q, 16'h001E);
        chk({ptr_waddr_q, mem_waddr_q[11:0]}, 16'h2002);
        chk(ptr_wdata_q, 16'h0902);
        chk(ind_rd_addr, 16'h0900);
        chk({15'h0, ptr_we_q}, 16'h1);
        run(24'hD00063);
        chk({14'h0, illegal_q, default_work_reg_we_q}, 16'h2);
        $display("register form done");
        p.regs[2] = 16'h78A9;
        for (k = 0; k < 16; k++)
        begin
            run({16'hDD14, 4'h4, k[3:0]});
            e = 16'h78A9 << k;
            chk(default_work_reg_wdata_q, e);
            esr = fl(esr, e, 0, 0, 1);
            chk(processor_status_word_q, esr);
        end
        p.regs[0] = 16'h09A4;
        for (k = 0; k < 32; k++)
        begin
            p.regs[1] = 16'hFFE0 | k[15:0];
            run(24'hDD0101);
            e = k > 15 ? 16'h0 : 16'h09A4 << k;
            chk({default_work_reg_waddr_q, default_work_reg_wdata_q[11:0]}, {4'h2, e[11:0]});
            chk(default_work_reg_wdata_q, e);
        end
        run(24'hDD0121);
        chk({14'h0, illegal_q, default_work_reg_we_q}, 16'h2);
        $display("multi-bit forms done");
        @(posedge clock);
        for (k = 0; k < 300; k++)
        begin
            lf = nx(lf);
            #1 instr_valid = 1;
            p.regs[lf[3:0]] = lf[31:16];
            p.mem_word = lf[27:12];
            instr_word = lf[16] ? {8'hDD, 1'b0, lf[14:7], lf[5], 2'h0, lf[3:0]}
                                : {8'hD4, 1'b0, lf[14:0]};
            @(posedge clock);
        end
        #1 instr_valid = 0;
        $display("random stream done");
        summarize();
    end
endmodule // test_shift_left_unit
